//--- logic/usc_pkg.sv
// Constants, types and register map of the UART status and line control block
//
// Summary of operation
// - Loopback bit forces serial output high
// - Control bit 1 drives request-to-send low
// - Control bit 0 drives terminal-ready low
// - Transmitter idle when holding and shifter empty
// - Holding empty as soon as holding drained
// - Long low receive line flags break
// - Bad stop bit flags framing error
// - Bad parity bit flags parity error
// - Unread character overwritten flags overrun
// - New character sets data ready
// - Line status interrupt from error flags
// - Transmit interrupt set when holding drains to the shifter, not at reset
// - Receive interrupt when buffer full
// - Identify encodes highest pending source
// - Reads and writes clear interrupt sources
// - Modem status read clears modem interrupt
// - Sixteen bit fractional divider, reset zero
// - Divisor access bit remaps shared addresses
// - Only first stop bit is checked
// - Divider bit 15 selects fractional generator
package usc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_DATA = 32'hFFFF0800;
  localparam logic [31:0] OFS_IRQ_ENABLE = 32'hFFFF0804;
  localparam logic [31:0] OFS_IRQ_IDENTIFY = 32'hFFFF0808;
  localparam logic [31:0] OFS_LINE_CONTROL_A = 32'hFFFF080C;
  localparam logic [31:0] OFS_LINE_CONTROL_B = 32'hFFFF0810;
  localparam logic [31:0] OFS_LINE_STATUS = 32'hFFFF0814;
  localparam logic [31:0] OFS_MODEM_STATUS = 32'hFFFF0818;
  localparam logic [31:0] OFS_FRACTIONAL_DIVIDER = 32'hFFFF082C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LCA_DIVISOR_ACCESS = 7;
  localparam int LCA_SET_BREAK = 6;
  localparam int LCA_STICK = 5;
  localparam int LCA_EVEN = 4;
  localparam int LCA_PARITY_EN = 3;
  localparam int LCA_STOP = 2;
  localparam int LCB_LOOPBACK = 4;
  localparam int LCB_RTS = 1;
  localparam int LCB_DTR = 0;
  localparam int IEN_MODEM = 3;
  localparam int IEN_LINE_STATUS = 2;
  localparam int IEN_TX_EMPTY = 1;
  localparam int IEN_RX_FULL = 0;
  localparam int FD_GEN_ENABLE = 15;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_STATUS_RESET = 8'h60;
  localparam logic [7:0] IRQ_IDENTIFY_RESET = 8'h01;
  localparam logic [1:0] IID_LINE = 2'h3;
  localparam logic [1:0] IID_RX = 2'h2;
  localparam logic [1:0] IID_TX = 2'h1;
  localparam logic [1:0] IID_MODEM = 2'h0;

  // ----------------------------------------------------------------
  // Timing in sixteenth-bit ticks
  // ----------------------------------------------------------------
  localparam logic [4:0] TICK_MID = 5'h07;
  localparam logic [4:0] TICK_LAST = 5'h0F;
  localparam logic [4:0] TICK_STOP_HALF = 5'h17;
  localparam logic [4:0] TICK_STOP_TWO = 5'h1F;
  localparam int BREAK_BITS = 12;
  localparam logic [8:0] BREAK_TICKS = 9'(BREAK_BITS * 16);

  // Serial frame phases, Gray coded along the frame
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_START = 3'h1,
    PH_DATA = 3'h3,
    PH_PARITY = 3'h2,
    PH_STOP = 3'h6
  } usc_phase_e;

  // Register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wrData;
    logic wr;
    logic rd;
  } usc_bus_s;

  // Line status flags
  typedef struct packed {
    logic transmitter_idle;
    logic holding_empty;
    logic brk;
    logic fe;
    logic pe;
    logic oe;
    logic dr;
  } usc_status_s;

endpackage

//--- logic/usc_uart_status.sv
// UART status, interrupt identification, line control and baud timing
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module usc_uart_status
  import usc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire usc_bus_s busReq,
  output logic [31:0] rdData,
  // Serial line
  input wire logic serialRxPin,
  output logic serialTxPin,
  // Modem lines
  input wire logic ctsPin_n,
  input wire logic dsrPin_n,
  output logic rtsPin_n,
  output logic dtrPin_n,
  // Interrupt request
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lcrA;
    logic [7:0] lcrB;
    logic [7:0] ien;
    logic [15:0] div;
    logic [15:0] frac;
    logic [7:0] rxBuf;
    logic [7:0] thr;
    usc_status_s st;
    logic thrIrq;
    logic dCts;
    logic dDsr;
    logic ctsPrev;
    logic dsrPrev;
    logic [15:0] baudCnt;
    logic [10:0] fracAcc;
    logic stretch;
    usc_phase_e txPh;
    logic [4:0] txCnt;
    logic [2:0] txBits;
    logic [7:0] txSh;
    logic txPar;
    logic txLine;
    usc_phase_e rxPh;
    logic [4:0] rxCnt;
    logic [2:0] rxBits;
    logic [7:0] rxSh;
    logic rxPar;
    logic [8:0] brkCnt;
    logic brkHeld;
    logic [31:0] rdData;
    logic txPin;
    logic rts_n;
    logic dtr_n;
    logic irq;
  } usc_state_s;

  usc_state_s q;
  usc_state_s d;

  // Decoded access and helper terms
  logic divisor_access;
  logic wrTx;
  logic rdRx;
  logic rdLsr;
  logic rdIid;
  logic rdMsr;
  logic tick;
  logic rxIn;
  logic [15:0] divEnd;
  logic [11:0] fracSum;
  logic [2:0] wlenM1;
  logic [7:0] rxWord;
  logic expPar;
  logic [4:0] stopEnd;
  logic pendLine;
  logic pendRx;
  logic pendTx;
  logic pendModem;
  logic [7:0] iid;
  logic [7:0] lsr;
  logic [7:0] msr;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  assign divisor_access = q.lcrA[LCA_DIVISOR_ACCESS];
  assign wrTx = busReq.wr && busReq.addr == OFS_DATA && !divisor_access;
  assign rdRx = busReq.rd && busReq.addr == OFS_DATA && !divisor_access;
  assign rdLsr = busReq.rd && busReq.addr == OFS_LINE_STATUS;
  assign rdIid = busReq.rd && busReq.addr == OFS_IRQ_IDENTIFY;
  assign rdMsr = busReq.rd && busReq.addr == OFS_MODEM_STATUS;

  // Status views
  assign lsr = {1'b0, q.st.transmitter_idle, q.st.holding_empty, q.st.brk, q.st.fe, q.st.pe, q.st.oe, q.st.dr};
  assign msr = {2'b00, ~dsrPin_n, ~ctsPin_n, 2'b00, q.dDsr, q.dCts};

  // ----------------------------------------------------------------
  // Interrupt sources and identification
  // ----------------------------------------------------------------
  assign pendLine = q.ien[IEN_LINE_STATUS] && (q.st.fe || q.st.pe || q.st.oe);
  assign pendTx = q.ien[IEN_TX_EMPTY] && q.thrIrq;
  assign pendRx = q.ien[IEN_RX_FULL] && q.st.dr;
  assign pendModem = q.ien[IEN_MODEM] && (q.dCts || q.dDsr);

  // Priority encoder for the identify register
  always_comb
  begin
    iid = IRQ_IDENTIFY_RESET;
    if (pendLine)
      iid = {5'h00, IID_LINE, 1'b0};
    else if (pendRx)
      iid = {5'h00, IID_RX, 1'b0};
    else if (pendTx)
      iid = {5'h00, IID_TX, 1'b0};
    else if (pendModem)
      iid = {5'h00, IID_MODEM, 1'b0};
  end

  // ----------------------------------------------------------------
  // Baud tick, sixteen per bit
  // ----------------------------------------------------------------
  assign divEnd = (q.div == 16'h0000) ? 16'h0000 : q.div - 16'h0001;
  // Compare with >= so a smaller divisor cannot strand the counter past its end
  assign tick = (q.baudCnt >= divEnd) && !q.stretch;
  assign fracSum = {1'b0, q.fracAcc} + {1'b0, q.frac[10:0]};

  // Frame geometry from the first line control register
  assign wlenM1 = {1'b1, q.lcrA[1:0]};
  assign stopEnd = !q.lcrA[LCA_STOP] ? TICK_LAST : (q.lcrA[1:0] == 2'b00) ? TICK_STOP_HALF : TICK_STOP_TWO;
  assign rxIn = q.lcrB[LCB_LOOPBACK] ? q.txLine : serialRxPin;
  assign rxWord = q.rxSh >> (3'h3 - {1'b0, q.lcrA[1:0]});
  assign expPar = q.lcrA[LCA_STICK] ? q.lcrA[LCA_EVEN] : (q.rxPar ^ ~q.lcrA[LCA_EVEN]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;

    // Baud counter; fractional mode stretches one cycle on carry
    if (q.stretch)
      d.stretch = 1'b0;
    else if (tick)
    begin
      d.baudCnt = 16'h0000;
      if (q.frac[FD_GEN_ENABLE])
      begin
        d.fracAcc = fracSum[10:0];
        d.stretch = fracSum[11];
      end
    end
    else
      d.baudCnt = q.baudCnt + 16'h0001;

    // Bus writes
    if (busReq.wr)
    begin
      case (busReq.addr)
        OFS_DATA:
        begin
          if (divisor_access)
            d.div[7:0] = busReq.wrData[7:0];
          else
          begin
            d.thr = busReq.wrData[7:0];
            d.st.holding_empty = 1'b0;
            d.st.transmitter_idle = 1'b0;
            d.thrIrq = 1'b0;
          end
        end
        OFS_IRQ_ENABLE:
        begin
          if (divisor_access)
            d.div[15:8] = busReq.wrData[7:0];
          else
            d.ien = busReq.wrData[7:0];
        end
        OFS_LINE_CONTROL_A: d.lcrA = busReq.wrData[7:0];
        OFS_LINE_CONTROL_B: d.lcrB = busReq.wrData[7:0];
        OFS_FRACTIONAL_DIVIDER: d.frac = busReq.wrData[15:0];
        default: d.lcrB = q.lcrB;
      endcase
    end

    // Read side effects; hardware sets below win
    if (rdLsr)
    begin
      d.st.brk = 1'b0;
      d.st.fe = 1'b0;
      d.st.pe = 1'b0;
      d.st.oe = 1'b0;
    end
    if (rdRx)
      d.st.dr = 1'b0;
    if (rdIid && iid[2:1] == IID_TX && !iid[0])
      d.thrIrq = 1'b0;
    if (rdMsr)
    begin
      d.dCts = 1'b0;
      d.dDsr = 1'b0;
    end

    // Modem line change detection
    d.ctsPrev = ctsPin_n;
    d.dsrPrev = dsrPin_n;
    if (ctsPin_n != q.ctsPrev)
      d.dCts = 1'b1;
    if (dsrPin_n != q.dsrPrev)
      d.dDsr = 1'b1;

    // Transmitter: load from holding register when idle
    if (q.txPh == PH_IDLE)
    begin
      if (!q.st.holding_empty && !wrTx)
      begin
        d.txSh = q.thr;
        d.txPar = 1'b0;
        d.txPh = PH_START;
        d.txCnt = 5'h00;
        d.st.holding_empty = 1'b1;
        d.thrIrq = 1'b1;
      end
      else if (q.st.holding_empty && !wrTx)
        d.st.transmitter_idle = 1'b1;
    end
    else if (tick)
    begin
      d.txCnt = q.txCnt + 5'h01;
      case (q.txPh)
        PH_START:
        begin
          if (q.txCnt == TICK_LAST)
          begin
            d.txPh = PH_DATA;
            d.txCnt = 5'h00;
            d.txBits = 3'h0;
          end
        end
        PH_DATA:
        begin
          if (q.txCnt == TICK_LAST)
          begin
            d.txCnt = 5'h00;
            d.txPar = q.txPar ^ q.txSh[0];
            d.txSh = {1'b0, q.txSh[7:1]};
            d.txBits = q.txBits + 3'h1;
            if (q.txBits == wlenM1)
              d.txPh = q.lcrA[LCA_PARITY_EN] ? PH_PARITY : PH_STOP;
          end
        end
        PH_PARITY:
        begin
          if (q.txCnt == TICK_LAST)
          begin
            d.txCnt = 5'h00;
            d.txPh = PH_STOP;
          end
        end
        PH_STOP:
        begin
          if (q.txCnt == stopEnd)
            d.txPh = PH_IDLE;
        end
        default: d.txPh = PH_IDLE;
      endcase
    end

    // Serial level for the current transmit phase
    case (d.txPh)
      PH_START: d.txLine = 1'b0;
      PH_DATA: d.txLine = d.txSh[0];
      PH_PARITY: d.txLine = q.lcrA[LCA_STICK] ? q.lcrA[LCA_EVEN] : (d.txPar ^ ~q.lcrA[LCA_EVEN]);
      default: d.txLine = 1'b1;
    endcase

    // Break detection: low for longer than the longest frame
    if (rxIn)
    begin
      d.brkCnt = 9'h000;
      d.brkHeld = 1'b0;
    end
    else if (tick && !q.brkHeld)
    begin
      d.brkCnt = q.brkCnt + 9'h001;
      if (q.brkCnt == BREAK_TICKS)
      begin
        d.st.brk = 1'b1;
        d.brkHeld = 1'b1;
      end
    end

    // Receiver
    if (tick)
    begin
      d.rxCnt = q.rxCnt + 5'h01;
      case (q.rxPh)
        PH_IDLE:
        begin
          d.rxCnt = 5'h00;
          if (!rxIn && !q.brkHeld)
            d.rxPh = PH_START;
        end
        PH_START:
        begin
          if (q.rxCnt == TICK_MID)
          begin
            d.rxCnt = 5'h00;
            d.rxBits = 3'h0;
            d.rxPar = 1'b0;
            d.rxPh = rxIn ? PH_IDLE : PH_DATA;
          end
        end
        PH_DATA:
        begin
          if (q.rxCnt == TICK_LAST)
          begin
            d.rxCnt = 5'h00;
            d.rxSh = {rxIn, q.rxSh[7:1]};
            d.rxPar = q.rxPar ^ rxIn;
            d.rxBits = q.rxBits + 3'h1;
            if (q.rxBits == wlenM1)
              d.rxPh = q.lcrA[LCA_PARITY_EN] ? PH_PARITY : PH_STOP;
          end
        end
        PH_PARITY:
        begin
          if (q.rxCnt == TICK_LAST)
          begin
            d.rxCnt = 5'h00;
            if (rxIn != expPar)
              d.st.pe = 1'b1;
            d.rxPh = PH_STOP;
          end
        end
        PH_STOP:
        begin
          // Only the first stop bit is sampled
          if (q.rxCnt == TICK_LAST)
          begin
            d.rxPh = PH_IDLE;
            d.rxBuf = rxWord;
            if (!rxIn)
              d.st.fe = 1'b1;
            if (q.st.dr && !rdRx)
              d.st.oe = 1'b1;
            d.st.dr = 1'b1;
          end
        end
        default: d.rxPh = PH_IDLE;
      endcase
    end

    // Registered read data, valid the cycle after the strobe
    d.rdData = 32'h00000000;
    if (busReq.rd)
    begin
      case (busReq.addr)
        OFS_DATA: d.rdData = {24'h000000, divisor_access ? q.div[7:0] : q.rxBuf};
        OFS_IRQ_ENABLE: d.rdData = {24'h000000, divisor_access ? q.div[15:8] : q.ien};
        OFS_IRQ_IDENTIFY: d.rdData = {24'h000000, iid};
        OFS_LINE_CONTROL_A: d.rdData = {24'h000000, q.lcrA};
        OFS_LINE_CONTROL_B: d.rdData = {24'h000000, q.lcrB};
        OFS_LINE_STATUS: d.rdData = {24'h000000, lsr};
        OFS_MODEM_STATUS: d.rdData = {24'h000000, msr};
        OFS_FRACTIONAL_DIVIDER: d.rdData = {16'h0000, q.frac};
        default: d.rdData = 32'h00000000;
      endcase
    end

    // Pin drivers; loopback wins over set-break
    if (q.lcrB[LCB_LOOPBACK])
      d.txPin = 1'b1;
    else if (q.lcrA[LCA_SET_BREAK])
      d.txPin = 1'b0;
    else
      d.txPin = q.txLine;
    d.rts_n = ~q.lcrB[LCB_RTS];
    d.dtr_n = ~q.lcrB[LCB_DTR];
    d.irq = pendLine || pendRx || pendTx || pendModem;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= usc_status_s'({LINE_STATUS_RESET[6:5], 5'h00});
      q.txPh <= PH_IDLE;
      q.rxPh <= PH_IDLE;
      q.txLine <= 1'b1;
      q.txPin <= 1'b1;
      q.rts_n <= 1'b1;
      q.dtr_n <= 1'b1;
      q.ctsPrev <= 1'b1;
      q.dsrPrev <= 1'b1;
    end
    else
      q <= d;
  end

  // Outputs straight from flip-flops
  assign rdData = q.rdData;
  assign serialTxPin = q.txPin;
  assign rtsPin_n = q.rts_n;
  assign dtrPin_n = q.dtr_n;
  assign irq = q.irq;

endmodule

//--- sim/usc_remote_peer.sv
// Remote serial transceiver model for the line side
`timescale 1ns/100ps
module usc_remote_peer
(
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic lineFromDut,
  output logic lineToDut
);
  localparam int BitCycles = 16;
  int txStarts = 0;
  logic [7:0] gotByte = 8'h00;

  // Line idles high between frames
  initial lineToDut = 1'b1;

  // Count frames from the block and catch eight data bits at mid-bit
  always @(negedge lineFromDut)
  begin
    txStarts++;
    repeat (BitCycles / 2) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BitCycles) @(posedge clock);
      gotByte[i] = lineFromDut;
    end
  end

  // Start bit, then count bits LSB first
  task automatic send_frame(input logic [9:0] frame, input int count);
    @(posedge clock);
    lineToDut <= 1'b0;
    repeat (BitCycles) @(posedge clock);
    for (int i = 0; i < count; i++)
    begin
      lineToDut <= frame[i];
      repeat (BitCycles) @(posedge clock);
    end
    lineToDut <= 1'b1;
  endtask

  // Hold the line low for a break
  task automatic hold_low(input int cycles);
    @(posedge clock);
    lineToDut <= 1'b0;
    repeat (cycles) @(posedge clock);
    lineToDut <= 1'b1;
  endtask
endmodule

//--- sim/usc_uart_status_assertions.sv
// Checker for readback, pin control and interrupt gating
`timescale 1ns/100ps
module usc_uart_status_checker
  import usc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire usc_bus_s busReq,
  input wire logic [31:0] rdData,
  // Serial and modem pins
  input wire logic serialRxPin,
  input wire logic serialTxPin,
  input wire logic ctsPin_n,
  input wire logic dsrPin_n,
  input wire logic rtsPin_n,
  input wire logic dtrPin_n,
  // Interrupt
  input wire logic irq
);
  // ----
  // Register mirrors
  // ----
  logic [7:0] lcbQ;
  logic [7:0] ienQ;
  logic dlabQ;
  logic [15:0] fdQ;

  // Track writes as software sees them
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lcbQ <= 8'h00;
      ienQ <= 8'h00;
      dlabQ <= 1'b0;
      fdQ <= 16'h0000;
    end
    else if (busReq.wr)
    begin
      if (busReq.addr == OFS_LINE_CONTROL_B) lcbQ <= busReq.wrData[7:0];
      if (busReq.addr == OFS_LINE_CONTROL_A) dlabQ <= busReq.wrData[LCA_DIVISOR_ACCESS];
      if (busReq.addr == OFS_IRQ_ENABLE && !dlabQ) ienQ <= busReq.wrData[7:0];
      if (busReq.addr == OFS_FRACTIONAL_DIVIDER) fdQ <= busReq.wrData[15:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----
  // Properties
  // ----
  a_loop_tx_high: assert property (lcbQ[LCB_LOOPBACK] && $past(lcbQ[LCB_LOOPBACK]) |-> serialTxPin)
    else $error("tx pin low in loopback");
  a_rts_follow: assert property ($stable(lcbQ) |-> rtsPin_n == !lcbQ[LCB_RTS])
    else $error("rts pin wrong");
  a_dtr_follow: assert property ($stable(lcbQ) |-> dtrPin_n == !lcbQ[LCB_DTR])
    else $error("dtr pin wrong");
  a_empty_order: assert property ($past(busReq.rd && busReq.addr == OFS_LINE_STATUS)
    |-> (!rdData[6] || rdData[5]) && !rdData[7])
    else $error("idle without holding empty");
  a_ident_idle: assert property ($past(busReq.rd && busReq.addr == OFS_IRQ_IDENTIFY)
    |-> rdData[7:3] == 5'h00 && (!rdData[0] || rdData[2:1] == 2'h0))
    else $error("identify code bad");
  a_divider_back: assert property ($past(busReq.rd && busReq.addr == OFS_FRACTIONAL_DIVIDER)
    |-> rdData == {16'h0000, fdQ})
    else $error("divider readback");
  a_enable_back: assert property ($past(busReq.rd && busReq.addr == OFS_IRQ_ENABLE && !dlabQ)
    |-> rdData[3:0] == ienQ[3:0])
    else $error("enable readback");
  a_irq_masked: assert property (ienQ == 8'h00 && $past(ienQ) == 8'h00 |-> !irq)
    else $error("irq with sources off");
  a_rd_idle: assert property (!$past(busReq.rd) |-> rdData == 32'h0000_0000)
    else $error("read data outside slot");

  // Main scenarios reached
  c_loopback: cover property (lcbQ[LCB_LOOPBACK]);
  c_irq_up: cover property ($rose(irq));
  c_rx_read: cover property ($past(busReq.rd && busReq.addr == OFS_DATA) && rdData != 32'h0);
endmodule

bind usc_uart_status usc_uart_status_checker chk_u (
  .clock(clock), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
  .serialRxPin(serialRxPin), .serialTxPin(serialTxPin), .ctsPin_n(ctsPin_n),
  .dsrPin_n(dsrPin_n), .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n), .irq(irq)
);

//--- sim/usc_uart_status_tb_top.sv
// Self-checking bench for the UART status and line control block
`timescale 1ns/100ps
module usc_uart_status_tb_top
  import usc_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  usc_bus_s busReq = '0;
  logic [31:0] rdData;
  logic serialRxPin;
  logic serialTxPin;
  logic rtsPin_n;
  logic dtrPin_n;
  logic irq;
  logic ctsPin_n = 1'b1;
  logic dsrPin_n = 1'b1;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] expQ[$];
  logic [31:0] note;
  logic rdLast = 1'b0;
  logic [7:0] d;
  logic [15:0] r;
  logic [15:0] flagBit[3] = '{16'h0008, 16'h0004, 16'h0010};

  initial forever #4 clock = ~clock;

  usc_uart_status dut_u (.clock(clock), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
    .serialRxPin(serialRxPin), .serialTxPin(serialTxPin), .ctsPin_n(ctsPin_n),
    .dsrPin_n(dsrPin_n), .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n), .irq(irq));
  usc_remote_peer peer_u (.clock(clock), .lineFromDut(serialTxPin), .lineToDut(serialRxPin));

  // ----
  // Tasks
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] e, input logic [15:0] m);
    n_checks++;
    if ((got & m) !== (e & m))
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, e);
    end
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge clock);
    busReq.addr <= a;
    busReq.wrData <= {16'h0000, v};
    busReq.wr <= 1'b1;
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [31:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clock);
    expQ.push_back({e, m});
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clock);
    busReq.rd <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read data checked one cycle after each read
  always @(posedge clock)
  begin
    if (rdLast && expQ.size() > 0)
    begin
      note = expQ.pop_front();
      check(rdData[15:0], note[31:16], note[15:0]);
    end
    rdLast <= busReq.rd;
  end

  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("unexpected at %0t: timeout", $time);
    test_done;
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    void'($urandom(13));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    bus_rd(OFS_LINE_STATUS, 16'h0060, 16'hFFFF);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0001, 16'hFFFF);
    bus_rd(OFS_FRACTIONAL_DIVIDER, 16'h0000, 16'hFFFF);
    bus_rd(32'hFFFF0840, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(OFS_LINE_CONTROL_B, 16'(i));
      repeat (2) @(posedge clock);
      check({14'h0, rtsPin_n, dtrPin_n}, 16'(~i & 3), 16'h0003);
    end
    r = 16'($urandom());
    bus_wr(OFS_FRACTIONAL_DIVIDER, r);
    bus_rd(OFS_FRACTIONAL_DIVIDER, r, 16'hFFFF);
    bus_wr(OFS_FRACTIONAL_DIVIDER, 16'h0000);
    // Transmit with its interrupt enabled
    bus_wr(OFS_LINE_CONTROL_A, 16'h0003);
    bus_wr(OFS_IRQ_ENABLE, 16'h0002);
    d = 8'($urandom());
    bus_wr(OFS_DATA, {8'h00, d});
    bus_rd(OFS_LINE_STATUS, 16'h0020, 16'h0060);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0002, 16'h0007);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0001, 16'h0007);
    repeat (200) @(posedge clock);
    bus_rd(OFS_LINE_STATUS, 16'h0060, 16'hFFFF);
    check({8'h00, peer_u.gotByte}, {8'h00, d}, 16'h00FF);
    // Loopback keeps the pin high; fractional mode roughly doubles the frame
    bus_wr(OFS_IRQ_ENABLE, 16'h0001);
    bus_wr(OFS_LINE_CONTROL_B, 16'h0010);
    bus_wr(OFS_FRACTIONAL_DIVIDER, 16'h87FF);
    bus_wr(OFS_DATA, {8'h00, d});
    repeat (200) @(posedge clock);
    check(16'(peer_u.txStarts), 16'h0001, 16'hFFFF);
    bus_rd(OFS_LINE_STATUS, 16'h0020, 16'h0060);
    repeat (200) @(posedge clock);
    bus_rd(OFS_LINE_STATUS, 16'h0061, 16'h0061);
    bus_rd(OFS_DATA, {8'h00, d}, 16'h00FF);
    bus_wr(OFS_FRACTIONAL_DIVIDER, 16'h0000);
    bus_wr(OFS_LINE_CONTROL_B, 16'h0000);
    // Receive one character
    d = 8'($urandom());
    peer_u.send_frame({2'b01, d}, 9);
    repeat (4) @(posedge clock);
    check({15'h0, irq}, 16'h0001, 16'h0001);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0004, 16'h0007);
    bus_rd(OFS_LINE_STATUS, 16'h0061, 16'hFFFF);
    bus_rd(OFS_DATA, {8'h00, d}, 16'h00FF);
    bus_rd(OFS_LINE_STATUS, 16'h0060, 16'hFFFF);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0001, 16'h0007);
    // Overrun with two stop bits set, frames sent with one
    bus_wr(OFS_LINE_CONTROL_A, 16'h0007);
    bus_wr(OFS_IRQ_ENABLE, 16'h0005);
    peer_u.send_frame({2'b01, d}, 9);
    peer_u.send_frame({2'b01, ~d}, 9);
    repeat (4) @(posedge clock);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0006, 16'h0007);
    bus_rd(OFS_LINE_STATUS, 16'h0063, 16'hFFFF);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0004, 16'h0007);
    bus_rd(OFS_DATA, {8'h00, ~d}, 16'h00FF);
    // Framing, parity and break flags
    for (int k = 0; k < 3; k++)
    begin
      bus_wr(OFS_LINE_CONTROL_A, k == 1 ? 16'h000B : 16'h0003);
      if (k == 0) peer_u.send_frame({2'b00, d}, 9);
      else if (k == 1) peer_u.send_frame({1'b1, ^d, d}, 10);
      else peer_u.hold_low(224);
      repeat (200) @(posedge clock);
      bus_rd(OFS_LINE_STATUS, flagBit[k], flagBit[k]);
      bus_rd(OFS_LINE_STATUS, 16'h0000, flagBit[k]);
      bus_rd(OFS_DATA, 16'h0000, 16'h0000);
    end
    // Modem interrupt cleared by its status read
    bus_wr(OFS_IRQ_ENABLE, 16'h0008);
    ctsPin_n <= 1'b0;
    repeat (6) @(posedge clock);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0000, 16'h0007);
    bus_rd(OFS_MODEM_STATUS, 16'h0001, 16'h0001);
    bus_rd(OFS_IRQ_IDENTIFY, 16'h0001, 16'h0007);
    // Divisor access remaps the enable address
    bus_wr(OFS_LINE_CONTROL_A, 16'h0083);
    bus_wr(OFS_IRQ_ENABLE, 16'h005A);
    bus_rd(OFS_IRQ_ENABLE, 16'h005A, 16'h00FF);
    bus_wr(OFS_IRQ_ENABLE, 16'h0000);
    bus_wr(OFS_LINE_CONTROL_A, 16'h0003);
    bus_rd(OFS_IRQ_ENABLE, 16'h0008, 16'h00FF);
    repeat (3) @(posedge clock);
    test_done;
  end
endmodule
